// >>> hw/mode_ctrl_defines.svh
`ifndef MODE_CTRL_DEFINES_SVH
`define MODE_CTRL_DEFINES_SVH

// serial configuration port
`define SR_LEN        20
`define BANK_W        18
`define BANK3_W       4
`define ADDR_BITS     2

// bank 0 field positions
`define F_FILT_B      0
`define F_OBSERVE     1
`define F_ERD_LO      2
`define F_ERD_W       2
`define F_CODE_INV    4
`define F_REF_EN      5
`define F_LOWZ_LONG   6
`define F_PRE_3T      7

// power-on presets
`define BANK0_RST     18'h00000
`define BANK1_RST     18'h00000
`define BANK2_RST     18'h00000
`define BANK3_RST     4'h0

// register port map
`define RA_W          4
`define RA_BANK0      4'h0
`define RA_BANK1      4'h1
`define RA_BANK2      4'h2
`define RA_BANK3      4'h3
`define RA_STATUS     4'h4

// status word bit positions
`define S_PREAMBLE    0
`define S_RG          1
`define S_WG          2
`define S_LOWZ        3
`define S_FLOCK       4
`define S_SCK_SYNC    5

// timing
`define CLK_MHZ       125
`define LOWZ_SHORT_NS 1700
`define LOWZ_LONG_NS  3400
`define LOWZ_SHORT_CYC ((`LOWZ_SHORT_NS * `CLK_MHZ + 999) / 1000)
`define LOWZ_LONG_CYC  ((`LOWZ_LONG_NS * `CLK_MHZ + 999) / 1000)
`define LOWZ_CNT_W    9
`define PRE_PULSES    16
`define PRE_CNT_W     5
`define PER_2T        2
`define PER_3T        3
`define IV_W          3

`endif

// >>> hw/mode_ctrl_pkg.sv
package mode_ctrl_pkg;

  typedef enum logic [1:0] {
    ERD_IDLE_LOW = 2'h0,
    ERD_OUTPUT   = 2'h1,
    ERD_INPUT    = 2'h2,
    ERD_RSVD     = 2'h3
  } erd_mode_t;

  // gray coded along idle -> writing -> holding
  typedef enum logic [1:0] {
    LZ_IDLE  = 2'h0,
    LZ_WRITE = 2'h1,
    LZ_HOLD  = 2'h3
  } lowz_state_t;

  typedef struct packed {
    logic      filt_b;
    logic      observe;
    erd_mode_t erd_mode;
    logic      code_inv;
    logic      ref_en;
    logic      lowz_long;
    logic      pre_3t;
  } cfg_t;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic reg_clock;
    logic reg_serial_data;
    logic reg_latch_shift_sel;
    logic read_gate;
    logic write_gate;
    logic freq_lock_ctrl;
    logic hold;
    logic early;
    logic late;
    logic detector_power_down_n;
    logic servo_sel_a;
    logic servo_sel_b;
    logic servo_sel_c;
    logic sync_clk;
    logic ref_out_a_clk;
    logic detected_pulse;
    logic encoded_pulse;
    logic code;
    logic zero_phase_start_done;
  } pins_t;

endpackage

// >>> hw/mode_ctrl.sv
// Function
// - shift serial bit on clock while select low
// - select high loads addressed bank, applies it
// - 20-bit shifter, last two bits address
// - presets at power-on only, not power-down
// - hold freezes AGC; coasts loop in read
// - early select shifts write pulse early
// - late select shifts write pulse late
// - detector power-down pin idles the detector only
// - glitch-free sync or ref_out_a clock select
// - read gate low forces frequency lock
// - lock control high ends lock, gates pulses
// - gates and lock control accepted anytime
// - preamble found after gate, start, 16 pulses
// - preamble flag latched until read gate drops
// - reference output low until enabled
// - configurable write data output polarity
// - write gate low-z plus programmable hold
// - encoded pulse pin off, output, or input
// - pin input replaces detected pulses when selected
// - hold high: gray code selects servo gate
// - hold low: discharge and AGC speed select
// - configuration selects filter A or B
// - observation mode repurposes servo capacitor pins
`timescale 1ns/100ps
`include "mode_ctrl_defines.svh"

module mode_ctrl (
  // clock, reset, enable
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // register port
  input  wire logic [`RA_W-1:0]     addr_in,
  input  wire logic [31:0]          wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [31:0]          rdata_out,
  // serial configuration pins
  input  wire logic                 reg_clock_in,
  input  wire logic                 reg_serial_data_in,
  input  wire logic                 reg_latch_shift_sel_in,
  // mode pins from the controller
  input  wire logic                 read_gate_in,
  input  wire logic                 write_gate_in,
  input  wire logic                 freq_lock_ctrl_in,
  input  wire logic                 hold_in,
  input  wire logic                 early_in,
  input  wire logic                 late_in,
  input  wire logic                 detector_power_down_n_in,
  input  wire logic                 servo_sel_a_in,
  input  wire logic                 servo_sel_b_in,
  input  wire logic                 servo_sel_c_in,
  input  wire logic                 zero_phase_start_done_in,
  // clocks and pulses from the analog side
  input  wire logic                 sync_clk_in,
  input  wire logic                 ref_out_a_clk_in,
  input  wire logic                 detected_pulse_in,
  input  wire logic                 code_in,
  // encoded pulse pin
  input  wire logic                 encoded_pulse_pin_in,
  output logic                      encoded_pulse_pin_out,
  output logic                      encoded_pulse_pin_oe_out,
  // clock and data outputs
  output logic                      sck_out,
  output logic                      ref_out_a_out,
  output logic                      code_out,
  output logic                      early_shift_out,
  output logic                      late_shift_out,
  output logic                      sync_pulse_out,
  // loop and detector control
  output logic                      agc_freeze_out,
  output logic                      phase_comp_en_out,
  output logic                      freq_lock_active_out,
  output logic                      pulse_gate_en_out,
  output logic                      preamble_found_out,
  output logic                      analog_low_z_out,
  output logic                      detector_off_out,
  output logic                      filter_b_sel_out,
  output logic                      observe_mode_out,
  // servo control
  output logic      [3:0]           servo_gate_out,
  output logic                      servo_discharge_out,
  output logic                      agc_fast_out
);

  localparam int LZ_SHORT = `LOWZ_SHORT_CYC;
  localparam int LZ_LONG  = `LOWZ_LONG_CYC;

  // two-stage synchronisers for every outside pin
  mode_ctrl_pkg::pins_t pins_raw;
  mode_ctrl_pkg::pins_t sync1_q;
  mode_ctrl_pkg::pins_t s_q;
  mode_ctrl_pkg::pins_t s_prev_q;

  assign pins_raw = {reg_clock_in, reg_serial_data_in, reg_latch_shift_sel_in, read_gate_in,
                     write_gate_in, freq_lock_ctrl_in, hold_in, early_in, late_in,
                     detector_power_down_n_in, servo_sel_a_in, servo_sel_b_in, servo_sel_c_in,
                     sync_clk_in, ref_out_a_clk_in, detected_pulse_in, encoded_pulse_pin_in, code_in,
                     zero_phase_start_done_in};

  // no timing relation assumed between gates, so all pass the same path
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q  <= '0;
      s_q      <= '0;
      s_prev_q <= '0;
    end else if (ce_in) begin
      sync1_q  <= pins_raw;
      s_q      <= sync1_q;
      s_prev_q <= s_q;
    end
  end

  wire reg_clk_rise  = s_q.reg_clock & ~s_prev_q.reg_clock;
  wire latch_rise    = s_q.reg_latch_shift_sel & ~s_prev_q.reg_latch_shift_sel;
  wire sync_clk_rise = s_q.sync_clk & ~s_prev_q.sync_clk;

  // serial configuration shifter and latch banks
  logic [`SR_LEN-1:0]  shift_q;
  logic [`BANK_W-1:0]  bank0_q;
  logic [`BANK_W-1:0]  bank1_q;
  logic [`BANK_W-1:0]  bank2_q;
  logic [`BANK3_W-1:0] bank3_q;

  wire                     shift_en  = reg_clk_rise & ~s_q.reg_latch_shift_sel;
  wire [`ADDR_BITS-1:0]    ser_addr  = shift_q[`ADDR_BITS-1:0];
  wire [`BANK_W-1:0]       ser_data  = shift_q[`SR_LEN-1:`ADDR_BITS];
  wire                     bus_wr_b0 = wr_in & (addr_in == `RA_BANK0);
  wire                     bus_wr_b1 = wr_in & (addr_in == `RA_BANK1);
  wire                     bus_wr_b2 = wr_in & (addr_in == `RA_BANK2);
  wire                     bus_wr_b3 = wr_in & (addr_in == `RA_BANK3);
  wire                     ld_b0     = latch_rise & (ser_addr == 2'h0);
  wire                     ld_b1     = latch_rise & (ser_addr == 2'h1);
  wire                     ld_b2     = latch_rise & (ser_addr == 2'h2);
  wire                     ld_b3     = latch_rise & (ser_addr == 2'h3);

  // first bit in ends up at the top, last two bits in are the address
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_q <= '0;
    end else if (ce_in && shift_en) begin
      shift_q <= {shift_q[`SR_LEN-2:0], s_q.reg_serial_data};
    end
  end

  // only rst_in presets banks; detector power-down never touches them
  // serial load wins over a bus write in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank0_q <= `BANK0_RST;
      bank1_q <= `BANK1_RST;
      bank2_q <= `BANK2_RST;
      bank3_q <= `BANK3_RST;
    end else if (ce_in) begin
      if (ld_b0) begin
        bank0_q <= ser_data;
      end else if (bus_wr_b0) begin
        bank0_q <= wdata_in[`BANK_W-1:0];
      end
      if (ld_b1) begin
        bank1_q <= ser_data;
      end else if (bus_wr_b1) begin
        bank1_q <= wdata_in[`BANK_W-1:0];
      end
      if (ld_b2) begin
        bank2_q <= ser_data;
      end else if (bus_wr_b2) begin
        bank2_q <= wdata_in[`BANK_W-1:0];
      end
      if (ld_b3) begin
        bank3_q <= ser_data[`BANK3_W-1:0];
      end else if (bus_wr_b3) begin
        bank3_q <= wdata_in[`BANK3_W-1:0];
      end
    end
  end

  mode_ctrl_pkg::cfg_t cfg;
  assign cfg = {bank0_q[`F_FILT_B], bank0_q[`F_OBSERVE], bank0_q[`F_ERD_LO +: `F_ERD_W],
                bank0_q[`F_CODE_INV], bank0_q[`F_REF_EN], bank0_q[`F_LOWZ_LONG],
                bank0_q[`F_PRE_3T]};

  // sync clock mux: switch only while output and new source are low
  logic sck_q;
  logic sck_sel_q;

  wire sck_want   = s_q.read_gate;
  wire sck_src    = sck_sel_q ? s_q.sync_clk : s_q.ref_out_a_clk;
  wire new_src    = sck_want ? s_q.sync_clk : s_q.ref_out_a_clk;
  wire sck_switch = (sck_want != sck_sel_q) & ~sck_q & ~new_src;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_sel_q <= 1'b0;
      sck_q     <= 1'b0;
    end else if (ce_in) begin
      if (sck_switch) begin
        sck_sel_q <= sck_want;
        sck_q     <= 1'b0;
      end else if (sck_want != sck_sel_q) begin
        sck_q     <= sck_q & sck_src;
      end else begin
        sck_q     <= sck_src;
      end
    end
  end

  // pulse source for the synchronizer and the encoded pulse pin
  wire erd_in_mode  = (cfg.erd_mode == mode_ctrl_pkg::ERD_INPUT);
  wire erd_out_mode = (cfg.erd_mode == mode_ctrl_pkg::ERD_OUTPUT);
  wire pulse_src    = erd_in_mode ? s_q.encoded_pulse : s_q.detected_pulse;
  logic pulse_prev_q;
  wire  pulse_rise  = pulse_src & ~pulse_prev_q;

  // preamble detector: spacing counted in synchronizer clock edges
  logic [`IV_W-1:0]      iv_q;
  logic [`PRE_CNT_W-1:0] pre_cnt_q;
  logic                  found_q;

  wire [`IV_W-1:0] period   = cfg.pre_3t ? `IV_W'(`PER_3T) : `IV_W'(`PER_2T);
  wire             arm      = s_q.read_gate & s_q.zero_phase_start_done;
  wire             spacing  = (iv_q == period);
  wire             pre_full = (pre_cnt_q == `PRE_CNT_W'(`PRE_PULSES));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulse_prev_q <= 1'b0;
      iv_q         <= '0;
      pre_cnt_q    <= '0;
      found_q      <= 1'b0;
    end else if (ce_in) begin
      pulse_prev_q <= pulse_src;
      if (!s_q.read_gate) begin
        iv_q      <= '0;
        pre_cnt_q <= '0;
        found_q   <= 1'b0;
      end else begin
        if (pulse_rise) begin
          iv_q <= '0;
        end else if (sync_clk_rise && iv_q != '1) begin
          iv_q <= iv_q + `IV_W'(1);
        end
        if (arm && pulse_rise && !pre_full) begin
          pre_cnt_q <= spacing ? pre_cnt_q + `PRE_CNT_W'(1) : '0;
        end
        if (arm && pre_full) begin
          found_q <= 1'b1;
        end
      end
    end
  end

  // input low-z hold after the write gate falls
  mode_ctrl_pkg::lowz_state_t lz_q;
  logic [`LOWZ_CNT_W-1:0]     lz_cnt_q;
  wire  [`LOWZ_CNT_W-1:0]     lz_load = `LOWZ_CNT_W'(cfg.lowz_long ? LZ_LONG : LZ_SHORT);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lz_q     <= mode_ctrl_pkg::LZ_IDLE;
      lz_cnt_q <= '0;
    end else if (ce_in) begin
      case (lz_q)
        mode_ctrl_pkg::LZ_IDLE: begin
          if (s_q.write_gate) lz_q <= mode_ctrl_pkg::LZ_WRITE;
        end
        mode_ctrl_pkg::LZ_WRITE: begin
          if (!s_q.write_gate) begin
            lz_q     <= mode_ctrl_pkg::LZ_HOLD;
            lz_cnt_q <= lz_load - `LOWZ_CNT_W'(1);
          end
        end
        mode_ctrl_pkg::LZ_HOLD: begin
          if (s_q.write_gate) begin
            lz_q <= mode_ctrl_pkg::LZ_WRITE;
          end else if (lz_cnt_q == '0) begin
            lz_q <= mode_ctrl_pkg::LZ_IDLE;
          end else begin
            lz_cnt_q <= lz_cnt_q - `LOWZ_CNT_W'(1);
          end
        end
        default: lz_q <= mode_ctrl_pkg::LZ_IDLE;
      endcase
    end
  end

  // servo decode: gray 000,001,011,010 picks bursts 0..3
  wire [2:0] gray = {s_q.servo_sel_c, s_q.servo_sel_b, s_q.servo_sel_a};
  logic [3:0] gate_dec;
  always_comb begin
    case (gray)
      3'h0:    gate_dec = 4'h1;
      3'h1:    gate_dec = 4'h2;
      3'h3:    gate_dec = 4'h4;
      3'h2:    gate_dec = 4'h8;
      default: gate_dec = 4'h0;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_out_a_out          <= 1'b0;
      code_out               <= 1'b0;
      early_shift_out        <= 1'b0;
      late_shift_out         <= 1'b0;
      sync_pulse_out         <= 1'b0;
      agc_freeze_out         <= 1'b0;
      phase_comp_en_out      <= 1'b1;
      freq_lock_active_out   <= 1'b1;
      pulse_gate_en_out      <= 1'b0;
      detector_off_out       <= 1'b0;
      filter_b_sel_out       <= 1'b0;
      observe_mode_out       <= 1'b0;
      servo_gate_out         <= 4'h0;
      servo_discharge_out    <= 1'b0;
      agc_fast_out           <= 1'b0;
      encoded_pulse_pin_out  <= 1'b0;
    end else if (ce_in) begin
      ref_out_a_out          <= cfg.ref_en & s_q.ref_out_a_clk;
      code_out               <= s_q.code ^ cfg.code_inv;
      early_shift_out        <= s_q.early;
      late_shift_out         <= s_q.late;
      sync_pulse_out         <= pulse_src;
      agc_freeze_out         <= s_q.hold;
      phase_comp_en_out      <= ~(s_q.hold & s_q.read_gate);
      freq_lock_active_out   <= ~s_q.read_gate | ~s_q.freq_lock_ctrl;
      pulse_gate_en_out      <= s_q.read_gate & s_q.freq_lock_ctrl;
      detector_off_out       <= ~s_q.detector_power_down_n;
      filter_b_sel_out       <= cfg.filt_b;
      observe_mode_out       <= cfg.observe;
      servo_gate_out         <= s_q.hold ? gate_dec : 4'h0;
      servo_discharge_out    <= ~s_q.hold & s_q.servo_sel_a;
      agc_fast_out           <= ~s_q.hold & s_q.servo_sel_b;
      encoded_pulse_pin_out  <= erd_out_mode & s_q.detected_pulse;
    end
  end

  assign sck_out                  = sck_q;
  assign preamble_found_out       = found_q;
  assign analog_low_z_out         = (lz_q != mode_ctrl_pkg::LZ_IDLE);
  assign encoded_pulse_pin_oe_out = ~erd_in_mode;

  // register read port, one cycle latency
  wire [31:0] status_word = {26'h0, sck_sel_q, freq_lock_active_out, analog_low_z_out,
                             s_q.write_gate, s_q.read_gate, found_q};
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_in)
      `RA_BANK0:  rd_mux = {14'h0, bank0_q};
      `RA_BANK1:  rd_mux = {14'h0, bank1_q};
      `RA_BANK2:  rd_mux = {14'h0, bank2_q};
      `RA_BANK3:  rd_mux = {28'h0, bank3_q};
      `RA_STATUS: rd_mux = status_word;
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else if (ce_in) begin
      rdata_out <= rd_in ? rd_mux : 32'h0;
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || !ce_in);
  sequence lz_write_end_s;
    $fell(s_q.write_gate) && lz_q == mode_ctrl_pkg::LZ_WRITE && !cfg.lowz_long;
  endsequence
  shift_capture_a: assert property (shift_en |=> shift_q[0] == $past(s_q.reg_serial_data))
    else $error("serial bit not shifted in");
  bank_load_a: assert property (ld_b0 |=> bank0_q == $past(ser_data))
    else $error("bank 0 not loaded from shifter");
  coast_read_a: assert property (s_q.hold && s_q.read_gate |=> !phase_comp_en_out)
    else $error("phase compare not suspended");
  lock_idle_a: assert property (!s_q.read_gate |=> freq_lock_active_out && !pulse_gate_en_out)
    else $error("frequency lock not forced");
  preamble_low_a: assert property (!s_q.read_gate |=> !preamble_found_out)
    else $error("preamble flag high without read gate");
  preamble_hold_a: assert property (preamble_found_out && s_q.read_gate |=> preamble_found_out)
    else $error("preamble flag dropped early");
  preamble_cause_a: assert property ($rose(preamble_found_out) |-> $past(pre_full && arm))
    else $error("preamble flag without full pulse count");
  lowz_short_a: assert property (lz_write_end_s |-> ##212 analog_low_z_out)
    else $error("low impedance released too soon");
  ref_gate_a: assert property (!cfg.ref_en |=> !ref_out_a_out)
    else $error("reference output active while disabled");
  servo_gray_a: assert property (s_q.hold && gray == 3'h3 |=> servo_gate_out == 4'h4)
    else $error("servo gray decode wrong");
  sck_glitch_a: assert property ($changed(sck_sel_q) |-> !sck_q && !$past(sck_q))
    else $error("clock source switched while high");

endmodule // mode_ctrl

// >>> bench/ctrl_model.sv
`timescale 1ns/100ps
module ctrl_model (
  // clock
  input  wire logic clk_in,
  // serial configuration pins
  output logic      reg_clock_out,
  output logic      reg_serial_data_out,
  output logic      reg_latch_shift_sel_out
);
  initial begin
    reg_clock_out = 1'b0;
    reg_serial_data_out = 1'b0;
    reg_latch_shift_sel_out = 1'b0;
  end

  // 64 ns link clock, four cycles a level; stands low between frames
  task automatic send(input logic [19:0] w);
    @(posedge clk_in);
    for (int i = 19; i >= 0; i--) begin
      reg_serial_data_out <= w[i];
      reg_clock_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      reg_clock_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    reg_clock_out <= 1'b0;
    // data released: inverse of the last bit, not a held value
    reg_serial_data_out <= ~reg_serial_data_out;
    repeat (4) @(posedge clk_in);
    reg_latch_shift_sel_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    reg_latch_shift_sel_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // ctrl_model

// >>> bench/read_channel_mode_control_tb_top.sv
`timescale 1ns/100ps
module read_channel_mode_control_tb_top;
  logic                 clk, rst, wr_s, rd_s, ce;
  logic [3:0]           addr;
  logic [31:0]          wdata;
  logic [6:0]           ex;
  mode_ctrl_pkg::pins_t p;
  wire logic [31:0]     rdata;
  wire logic [3:0]      gate;
  wire logic            sclk, sdat, ssel, e_out, e_oe, ref_o, code_o, early_o, late_o, sync_o;
  wire logic            frz, pce, flk, pge, pre, lowz, doff, filt, obs, dis, fast, sck_o;
  int                   n_fail, checked, cyc;
  logic [3:0]           gt [8] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0};
  wire logic            e_pin = e_oe ? e_out : p.encoded_pulse;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ctrl_model ctrl_u (.clk_in(clk), .reg_clock_out(sclk), .reg_serial_data_out(sdat),
    .reg_latch_shift_sel_out(ssel));

  mode_ctrl dut_u (
    .clk_in(clk), .rst_in(rst), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .reg_clock_in(sclk),
    .reg_serial_data_in(sdat), .reg_latch_shift_sel_in(ssel), .read_gate_in(p.read_gate),
    .write_gate_in(p.write_gate), .freq_lock_ctrl_in(p.freq_lock_ctrl), .hold_in(p.hold),
    .early_in(p.early), .late_in(p.late), .detector_power_down_n_in(p.detector_power_down_n),
    .servo_sel_a_in(p.servo_sel_a), .servo_sel_b_in(p.servo_sel_b),
    .servo_sel_c_in(p.servo_sel_c), .zero_phase_start_done_in(p.zero_phase_start_done),
    .sync_clk_in(p.sync_clk), .ref_out_a_clk_in(p.ref_out_a_clk), .detected_pulse_in(p.detected_pulse),
    .code_in(p.code), .encoded_pulse_pin_in(e_pin), .encoded_pulse_pin_out(e_out),
    .encoded_pulse_pin_oe_out(e_oe), .sck_out(sck_o), .ref_out_a_out(ref_o), .code_out(code_o),
    .early_shift_out(early_o), .late_shift_out(late_o), .sync_pulse_out(sync_o),
    .agc_freeze_out(frz), .phase_comp_en_out(pce), .freq_lock_active_out(flk),
    .pulse_gate_en_out(pge), .preamble_found_out(pre), .analog_low_z_out(lowz),
    .detector_off_out(doff), .filter_b_sel_out(filt), .observe_mode_out(obs),
    .servo_gate_out(gate), .servo_discharge_out(dis), .agc_fast_out(fast));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask

  // pins cross two sync flops and an output flop: five edges is margin
  task automatic settle();
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  // pulse while sync clock is low, every second rise, i.e. 2T spacing
  // a pulse on the same edge as a clock rise would hide that rise
  task automatic pulses(input int n);
    repeat (n) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        p.sync_clk <= ~k[0];
        p.detected_pulse <= (k == 1);
        @(posedge clk);
      end
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    {wr_s, rd_s, addr, wdata} = '0;
    p = '0;
    p.detector_power_down_n = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int b = 0; b < 4; b++) reg_rd(b[3:0], 32'h0);
    reg_rd(4'h4, 32'h10);
    reg_rd(4'h9, 32'h0);
    chk("pin_drive", 32'h2, 32'({e_oe, e_out}));
    $display("test reset done");

    ctrl_u.send({18'h2A5C3, 2'h0});
    reg_rd(4'h0, 32'h2A5C3);
    chk("filter_observe", 32'h3, 32'({filt, obs}));
    ctrl_u.send({18'h3FFF5, 2'h3});
    reg_rd(4'h3, 32'h5);
    reg_wr(4'h1, 32'hFFFFFFFF);
    reg_rd(4'h1, 32'h3FFFF);
    $display("test serial done");

    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      {p.read_gate, p.freq_lock_ctrl, p.hold, p.early, p.late, p.detector_power_down_n} <= i[5:0];
      settle();
      ex = {i[3], ~(i[3] & i[5]), ~i[5] | ~i[4], i[5] & i[4], i[2], i[1], ~i[0]};
      chk("loop_ctrl", 32'(ex), 32'({frz, pce, flk, pge, early_o, late_o, doff}));
    end
    @(posedge clk);
    p <= '0;
    reg_rd(4'h0, 32'h2A5C3);
    $display("test mode pins done");

    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {p.hold, p.servo_sel_c, p.servo_sel_b, p.servo_sel_a} <= i[3:0];
      settle();
      ex = i[3] ? {1'b0, gt[i[2:0]], 2'h0} : {5'h0, i[0], i[1]};
      chk("servo", 32'(ex), 32'({gate, dis, fast}));
    end
    $display("test servo done");

    @(posedge clk);
    p.code <= 1'b1;
    p.ref_out_a_clk <= 1'b1;
    settle();
    chk("ref_code", 32'h1, 32'({ref_o, code_o}));
    chk("sck", 32'h1, 32'(sck_o));
    reg_wr(4'h0, 32'h30);
    settle();
    chk("ref_code", 32'h2, 32'({ref_o, code_o}));
    @(posedge clk);
    p.ref_out_a_clk <= 1'b0;
    $display("test polarity done");

    for (int i = 0; i < 8; i++) begin
      reg_wr(4'h0, 32'(i[2:1]) << 2);
      @(posedge clk);
      p.detected_pulse <= i[0];
      p.encoded_pulse <= ~i[0];
      settle();
      ex = {4'h0, i[2:1] != 2'h2, i[2:1] == 2'h1 && i[0], i[2:1] == 2'h2 ? ~i[0] : i[0]};
      chk("pulse_pin", 32'(ex), 32'({e_oe, e_out, sync_o}));
    end
    $display("test pulse pin done");

    reg_wr(4'h0, 32'h0);
    @(posedge clk);
    p.read_gate <= 1'b1;
    p.zero_phase_start_done <= 1'b1;
    pulses(10);
    chk("preamble", 32'h0, 32'(pre));
    pulses(8);
    settle();
    chk("preamble", 32'h1, 32'(pre));
    repeat (40) @(posedge clk);
    reg_rd(4'h4, 32'h33);
    @(posedge clk);
    p.read_gate <= 1'b0;
    settle();
    chk("preamble", 32'h0, 32'(pre));
    $display("test preamble done");

    for (int l = 0; l < 2; l++) begin
      reg_wr(4'h0, 32'(l) << 6);
      @(posedge clk);
      p.write_gate <= 1'b1;
      settle();
      chk("low_z", 32'h1, 32'(lowz));
      @(posedge clk);
      p.write_gate <= 1'b0;
      repeat (l ? 410 : 200) @(posedge clk);
      settle();
      chk("low_z", 32'h1, 32'(lowz));
      repeat (l ? 25 : 20) @(posedge clk);
      settle();
      chk("low_z", 32'h0, 32'(lowz));
    end
    $display("test low impedance done");
    @(posedge clk);
    ce <= 1'b0;
    p.early <= 1'b1;
    settle();
    chk("freeze", 32'h0, 32'(early_o));
    @(posedge clk);
    ce <= 1'b1;
    settle();
    chk("freeze", 32'h1, 32'(early_o));
    $display("test clock enable done");
    close_out();
  end
endmodule // read_channel_mode_control_tb_top
